// >>> hdl/adb_data_buffer.sv
/*
 Antenna data buffer: egress and ingress channel buffer RAMs carved into
 per-channel FIFOs, with the frame timer that paces fill and drain.
 Assumes all inputs synchronous to clk (the dual-byte clock); config
 inputs stable while traffic flows.
*/
// Notes on behaviour
// - separate 16KB ingress and egress RAMs
// - channel start is 128 times base
// - DMA FIFO size is 128 shifted by depth
// - one direct buffer length, 128 or 256
// - full egress FIFO stalls the DMA writer
// - stream fill starts at first synced frame
// - control packets flow once link is synced
// - control payloads always use packet DMA
// - frame events every 10ms, triggers 4-32 chips
// - everything runs on the dual-byte clock
// - timers need arming and a sync pulse
`timescale 1ns/1ns
`default_nettype none
`include "adb_consts.svh"
module adb_data_buffer #(
   parameter int unsigned FRAME_CYCLES = `ADB_FRAME_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire adb_pkg::adb_base_arr_type chBase,
   input wire adb_pkg::adb_depth_arr_type chDepth,
   input wire adb_pkg::adb_chmask_type chDirect,
   input wire adb_pkg::adb_chmask_type chControl,
   input wire logic directLen256,
   input wire logic linkSyncedTx,
   input wire logic linkSyncedRx,
   input wire logic timerArm,
   input wire logic physicalTimerSyncInput,
   input wire logic radioTimerSyncInput,
   input wire adb_pkg::adb_tcnt_type offEnc1,
   input wire adb_pkg::adb_tcnt_type offEnc2,
   input wire adb_pkg::adb_tcnt_type offTxDelta,
   input wire adb_pkg::adb_tcnt_type offRxPi,
   input wire adb_pkg::adb_chips_type dioChips,
   input wire logic dmaWrValid,
   input wire adb_pkg::adb_ch_type dmaWrCh,
   input wire adb_pkg::adb_word_type dmaWrData,
   output logic dmaWrReady,
   input wire logic dioWrValid,
   input wire adb_pkg::adb_ch_type dioWrCh,
   input wire adb_pkg::adb_word_type dioWrData,
   input wire logic encRdReq,
   input wire adb_pkg::adb_ch_type encRdCh,
   output logic encRdValid,
   output adb_pkg::adb_word_type encRdData,
   input wire logic decWrValid,
   input wire adb_pkg::adb_ch_type decWrCh,
   input wire adb_pkg::adb_word_type decWrData,
   input wire logic ingRdReq,
   input wire adb_pkg::adb_ch_type ingRdCh,
   output logic ingRdValid,
   output adb_pkg::adb_word_type ingRdData,
   input wire logic ingDropClear,
   output logic ingDropped,
   output adb_pkg::adb_chmask_type egFull,
   output adb_pkg::adb_chmask_type egEmpty,
   output adb_pkg::adb_chmask_type ingFull,
   output adb_pkg::adb_chmask_type ingEmpty,
   output logic fillStarted,
   output logic frameTick,
   output logic evtEnc1,
   output logic evtEnc2,
   output logic evtTxDelta,
   output logic evtRxPi,
   output logic evtDio,
   output logic timerRunning
);
   import adb_pkg::*;

   // FIFO size in words for one channel
   function automatic adb_cnt_type chSize(input adb_depth_type depth, input logic direct,
                                          input logic len256);
      if (direct) begin
         chSize = len256 ? adb_cnt_type'(`ADB_DIO_LONG_WORDS)
                         : adb_cnt_type'(`ADB_DIO_SHORT_WORDS);
      end else begin
         chSize = adb_cnt_type'(adb_cnt_type'(`ADB_FIFO_UNIT_WORDS) << depth);
      end
   endfunction

   // RAM word index from base field and offset within the FIFO
   function automatic adb_idx_type chAddr(input adb_base_type base, input adb_idx_type off);
      chAddr = adb_idx_type'(adb_idx_type'(base) * adb_idx_type'(`ADB_BASE_UNIT_WORDS)
               + off);
   endfunction

   function automatic adb_idx_type ptrInc(input adb_idx_type p, input adb_cnt_type size);
      ptrInc = (adb_cnt_type'(p) + 1'b1 >= size) ? '0 : adb_idx_type'(p + 1'b1);
   endfunction

   function automatic adb_cnt_type cntStep(input adb_cnt_type c, input logic wr,
                                           input logic rd, input adb_cnt_type size);
      cntStep = c;
      if (wr && !rd && c < size) cntStep = adb_cnt_type'(c + 1'b1);
      if (rd && !wr && c != '0) cntStep = adb_cnt_type'(c - 1'b1);
   endfunction

   adb_buf_state_type st_ff;
   adb_buf_state_type nxt_st;
   adb_chmask_type dmaMode;
   adb_cnt_arr_type size;
   logic synced;
   logic egWe;
   adb_idx_type egWa;
   adb_word_type egWd;
   adb_idx_type egRa;
   logic encTake;
   logic ingWe;
   adb_idx_type ingWa;
   adb_idx_type ingRa;
   logic ingTake;
   logic [`ADB_NCH-1:0] egWr;
   logic [`ADB_NCH-1:0] egRd;
   logic [`ADB_NCH-1:0] ingWr;
   logic [`ADB_NCH-1:0] ingRd;
   adb_word_type egRam [0:`ADB_RAM_WORDS-1];
   adb_word_type ingRam [0:`ADB_RAM_WORDS-1];
   adb_word_type encRdData_ff;
   adb_word_type ingRdData_ff;

   adb_frame_timer #(
      .FRAME_CYCLES(FRAME_CYCLES)
   ) u_timer (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .timerArm(timerArm),
      .physSync(physicalTimerSyncInput),
      .radioSync(radioTimerSyncInput),
      .offEnc1(offEnc1),
      .offEnc2(offEnc2),
      .offTxDelta(offTxDelta),
      .offRxPi(offRxPi),
      .dioChips(dioChips),
      .frameTick(frameTick),
      .evtEnc1(evtEnc1),
      .evtEnc2(evtEnc2),
      .evtTxDelta(evtTxDelta),
      .evtRxPi(evtRxPi),
      .evtDio(evtDio),
      .timerRunning(timerRunning)
   );

   assign synced = linkSyncedTx && linkSyncedRx;
   assign dmaMode = ~chDirect | chControl;

   always_comb begin
      for (int i = 0; i < `ADB_NCH; i++) begin
         size[i] = chSize(chDepth[i], ~dmaMode[i], directLen256);
         egFull[i] = (st_ff.egCnt[i] >= size[i]);
         egEmpty[i] = (st_ff.egCnt[i] == '0);
         ingFull[i] = (st_ff.ingCnt[i] >= size[i]);
         ingEmpty[i] = (st_ff.ingCnt[i] == '0);
      end
   end

   // direct writes own the single egress write port, DMA yields a cycle
   always_comb begin
      dmaWrReady = 1'b0;
      if (dmaMode[dmaWrCh] && !dioWrValid && !egFull[dmaWrCh]) begin
         if (chControl[dmaWrCh]) begin
            dmaWrReady = synced;
         end else begin
            dmaWrReady = st_ff.fillStarted;
         end
      end
   end

   always_comb begin
      nxt_st = st_ff;
      // stream fill opens on the first frame boundary seen while synced
      if (!synced) begin
         nxt_st.fillStarted = 1'b0;
      end else if (frameTick) begin
         nxt_st.fillStarted = 1'b1;
      end
      for (int i = 0; i < `ADB_NCH; i++) begin
         egWr[i] = (dioWrValid && dioWrCh == adb_ch_type'(i) && !dmaMode[i])
                   || (dmaWrValid && dmaWrReady && dmaWrCh == adb_ch_type'(i));
         egRd[i] = encRdReq && encRdCh == adb_ch_type'(i) && (!dmaMode[i] || !egEmpty[i]);
         ingWr[i] = decWrValid && decWrCh == adb_ch_type'(i) && (!dmaMode[i] || !ingFull[i]);
         ingRd[i] = ingRdReq && ingRdCh == adb_ch_type'(i) && (!dmaMode[i] || !ingEmpty[i]);
         if (egWr[i]) nxt_st.egWr[i] = ptrInc(st_ff.egWr[i], size[i]);
         if (egRd[i]) nxt_st.egRd[i] = ptrInc(st_ff.egRd[i], size[i]);
         if (ingWr[i]) nxt_st.ingWr[i] = ptrInc(st_ff.ingWr[i], size[i]);
         if (ingRd[i]) nxt_st.ingRd[i] = ptrInc(st_ff.ingRd[i], size[i]);
         nxt_st.egCnt[i] = cntStep(st_ff.egCnt[i], egWr[i], egRd[i], size[i]);
         nxt_st.ingCnt[i] = cntStep(st_ff.ingCnt[i], ingWr[i], ingRd[i], size[i]);
      end
      egWe = |egWr;
      egWd = dioWrValid ? dioWrData : dmaWrData;
      egWa = dioWrValid ? chAddr(chBase[dioWrCh], st_ff.egWr[dioWrCh])
                        : chAddr(chBase[dmaWrCh], st_ff.egWr[dmaWrCh]);
      encTake = |egRd;
      egRa = chAddr(chBase[encRdCh], st_ff.egRd[encRdCh]);
      ingWe = |ingWr;
      ingWa = chAddr(chBase[decWrCh], st_ff.ingWr[decWrCh]);
      ingTake = |ingRd;
      ingRa = chAddr(chBase[ingRdCh], st_ff.ingRd[ingRdCh]);
      nxt_st.encRdValid = encTake;
      nxt_st.ingRdValid = ingTake;
      // decoder has no stall: a word into a full DMA FIFO is dropped
      if (decWrValid && !ingWe) begin
         nxt_st.ingDropped = 1'b1;
      end else if (ingDropClear) begin
         nxt_st.ingDropped = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // two separate storage arrays, one per direction
   always_ff @(posedge clk) begin
      if (ce) begin
         if (egWe) egRam[egWa] <= egWd;
         if (ingWe) ingRam[ingWa] <= decWrData;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         encRdData_ff <= '0;
         ingRdData_ff <= '0;
      end else if (ce) begin
         if (encTake) encRdData_ff <= egRam[egRa];
         if (ingTake) ingRdData_ff <= ingRam[ingRa];
      end
   end

   assign encRdValid = st_ff.encRdValid;
   assign encRdData = encRdData_ff;
   assign ingRdValid = st_ff.ingRdValid;
   assign ingRdData = ingRdData_ff;
   assign ingDropped = st_ff.ingDropped;
   assign fillStarted = st_ff.fillStarted;
endmodule // adb_data_buffer
`default_nettype wire

// >>> hdl/adb_consts.svh
/*
 Constants of the antenna data buffer: RAM geometry, field widths,
 clock rate and frame timing. Assumes nothing; included by bare name.
*/
`ifndef ADB_CONSTS_SVH
`define ADB_CONSTS_SVH
`define ADB_NCH 4
`define ADB_CH_W 2
`define ADB_DATA_W 32
`define ADB_WORD_BYTES 4
`define ADB_RAM_BYTES 16384
`define ADB_RAM_WORDS (`ADB_RAM_BYTES / `ADB_WORD_BYTES)
`define ADB_IDX_W 12
`define ADB_CNT_W 13
`define ADB_BASE_W 7
`define ADB_DEPTH_W 3
`define ADB_BASE_UNIT_BYTES 128
`define ADB_BASE_UNIT_WORDS (`ADB_BASE_UNIT_BYTES / `ADB_WORD_BYTES)
`define ADB_FIFO_UNIT_BYTES 128
`define ADB_FIFO_UNIT_WORDS (`ADB_FIFO_UNIT_BYTES / `ADB_WORD_BYTES)
`define ADB_DIO_SHORT_BYTES 128
`define ADB_DIO_LONG_BYTES 256
`define ADB_DIO_SHORT_WORDS (`ADB_DIO_SHORT_BYTES / `ADB_WORD_BYTES)
`define ADB_DIO_LONG_WORDS (`ADB_DIO_LONG_BYTES / `ADB_WORD_BYTES)
`define ADB_CLK_MHZ 125
`define ADB_FRAME_MS 10
`define ADB_FRAME_CYCLES (`ADB_FRAME_MS * 1000 * `ADB_CLK_MHZ)
`define ADB_CHIP_RATE_KHZ 3840
`define ADB_CHIP_CYCLES ((`ADB_CLK_MHZ * 1000) / `ADB_CHIP_RATE_KHZ)
`define ADB_DIO_MIN_CHIPS 4
`define ADB_DIO_MAX_CHIPS 32
`define ADB_CHIPS_W 6
`define ADB_TCNT_W 21
`define ADB_DCNT_W 11
`endif

// >>> hdl/adb_pkg.sv
/*
 Types of the antenna data buffer: config arrays, state records, timer modes.
 Assumes adb_consts.svh on the include path.
*/
`include "adb_consts.svh"
package adb_pkg;
   typedef logic [`ADB_DATA_W-1:0] adb_word_type;
   typedef logic [`ADB_CH_W-1:0] adb_ch_type;
   typedef logic [`ADB_IDX_W-1:0] adb_idx_type;
   typedef logic [`ADB_CNT_W-1:0] adb_cnt_type;
   typedef logic [`ADB_BASE_W-1:0] adb_base_type;
   typedef logic [`ADB_DEPTH_W-1:0] adb_depth_type;
   typedef logic [`ADB_NCH-1:0] adb_chmask_type;
   typedef logic [`ADB_NCH-1:0][`ADB_BASE_W-1:0] adb_base_arr_type;
   typedef logic [`ADB_NCH-1:0][`ADB_DEPTH_W-1:0] adb_depth_arr_type;
   typedef logic [`ADB_NCH-1:0][`ADB_IDX_W-1:0] adb_ptr_arr_type;
   typedef logic [`ADB_NCH-1:0][`ADB_CNT_W-1:0] adb_cnt_arr_type;
   typedef logic [`ADB_TCNT_W-1:0] adb_tcnt_type;
   typedef logic [`ADB_DCNT_W-1:0] adb_dcnt_type;
   typedef logic [`ADB_CHIPS_W-1:0] adb_chips_type;

   typedef enum logic [2:0] {
      TMR_IDLE = 3'h1,
      TMR_ARMED = 3'h2,
      TMR_RUN = 3'h4
   } adb_tmr_mode_type;

   typedef struct packed {
      adb_tmr_mode_type mode;
      adb_tmr_mode_type dioMode;
      adb_tcnt_type cnt;
      adb_dcnt_type dioCnt;
      logic frameTick;
      logic evtEnc1;
      logic evtEnc2;
      logic evtTxDelta;
      logic evtRxPi;
      logic evtDio;
   } adb_tmr_state_type;

   typedef struct packed {
      adb_ptr_arr_type egWr;
      adb_ptr_arr_type egRd;
      adb_cnt_arr_type egCnt;
      adb_ptr_arr_type ingWr;
      adb_ptr_arr_type ingRd;
      adb_cnt_arr_type ingCnt;
      logic fillStarted;
      logic encRdValid;
      logic ingRdValid;
      logic ingDropped;
   } adb_buf_state_type;
endpackage

// >>> hdl/adb_frame_timer.sv
/*
 Frame timer: 10 ms frame counter with four offset events, and a
 direct-transfer trigger with a period of 4 to 32 chips.
 Assumes sync inputs are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adb_consts.svh"
module adb_frame_timer #(
   parameter int unsigned FRAME_CYCLES = `ADB_FRAME_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic timerArm,
   input wire logic physSync,
   input wire logic radioSync,
   input wire adb_pkg::adb_tcnt_type offEnc1,
   input wire adb_pkg::adb_tcnt_type offEnc2,
   input wire adb_pkg::adb_tcnt_type offTxDelta,
   input wire adb_pkg::adb_tcnt_type offRxPi,
   input wire adb_pkg::adb_chips_type dioChips,
   output logic frameTick,
   output logic evtEnc1,
   output logic evtEnc2,
   output logic evtTxDelta,
   output logic evtRxPi,
   output logic evtDio,
   output logic timerRunning
);
   import adb_pkg::*;

   localparam adb_tcnt_type FRAME_LAST = adb_tcnt_type'(FRAME_CYCLES - 1);

   adb_tmr_state_type st_ff;
   adb_tmr_state_type nxt_st;
   adb_chips_type chipsC;
   adb_dcnt_type dioLast;

   always_comb begin
      // clamp trigger period into the supported chip range
      if (dioChips < adb_chips_type'(`ADB_DIO_MIN_CHIPS)) begin
         chipsC = adb_chips_type'(`ADB_DIO_MIN_CHIPS);
      end else if (dioChips > adb_chips_type'(`ADB_DIO_MAX_CHIPS)) begin
         chipsC = adb_chips_type'(`ADB_DIO_MAX_CHIPS);
      end else begin
         chipsC = dioChips;
      end
      dioLast = adb_dcnt_type'(adb_dcnt_type'(chipsC) * adb_dcnt_type'(`ADB_CHIP_CYCLES)
                - adb_dcnt_type'(1));
      nxt_st = st_ff;
      nxt_st.frameTick = 1'b0;
      nxt_st.evtEnc1 = 1'b0;
      nxt_st.evtEnc2 = 1'b0;
      nxt_st.evtTxDelta = 1'b0;
      nxt_st.evtRxPi = 1'b0;
      nxt_st.evtDio = 1'b0;
      // arm first, then a sync pulse starts counting
      case (st_ff.mode)
         TMR_IDLE: begin
            if (timerArm) nxt_st.mode = TMR_ARMED;
         end
         TMR_ARMED: begin
            if (!timerArm) begin
               nxt_st.mode = TMR_IDLE;
            end else if (physSync) begin
               nxt_st.mode = TMR_RUN;
               nxt_st.cnt = '0;
               nxt_st.frameTick = 1'b1;
            end
         end
         TMR_RUN: begin
            if (!timerArm) begin
               nxt_st.mode = TMR_IDLE;
            end else if (physSync || st_ff.cnt == FRAME_LAST) begin
               nxt_st.cnt = '0;
               nxt_st.frameTick = 1'b1;
            end else begin
               nxt_st.cnt = adb_tcnt_type'(st_ff.cnt + 1'b1);
            end
         end
         default: nxt_st.mode = TMR_IDLE;
      endcase
      if (nxt_st.mode == TMR_RUN) begin
         nxt_st.evtEnc1 = (nxt_st.cnt == offEnc1);
         nxt_st.evtEnc2 = (nxt_st.cnt == offEnc2);
         nxt_st.evtTxDelta = (nxt_st.cnt == offTxDelta);
         nxt_st.evtRxPi = (nxt_st.cnt == offRxPi);
      end
      // trigger timer, armed by the same enable, started by its own sync
      case (st_ff.dioMode)
         TMR_IDLE: begin
            if (timerArm) nxt_st.dioMode = TMR_ARMED;
         end
         TMR_ARMED: begin
            if (!timerArm) begin
               nxt_st.dioMode = TMR_IDLE;
            end else if (radioSync) begin
               nxt_st.dioMode = TMR_RUN;
               nxt_st.dioCnt = '0;
               nxt_st.evtDio = 1'b1;
            end
         end
         TMR_RUN: begin
            if (!timerArm) begin
               nxt_st.dioMode = TMR_IDLE;
            end else if (radioSync || st_ff.dioCnt >= dioLast) begin
               nxt_st.dioCnt = '0;
               nxt_st.evtDio = 1'b1;
            end else begin
               nxt_st.dioCnt = adb_dcnt_type'(st_ff.dioCnt + 1'b1);
            end
         end
         default: nxt_st.dioMode = TMR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '{mode: TMR_IDLE, dioMode: TMR_IDLE, default: '0};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign frameTick = st_ff.frameTick;
   assign evtEnc1 = st_ff.evtEnc1;
   assign evtEnc2 = st_ff.evtEnc2;
   assign evtTxDelta = st_ff.evtTxDelta;
   assign evtRxPi = st_ff.evtRxPi;
   assign evtDio = st_ff.evtDio;
   assign timerRunning = (st_ff.mode == TMR_RUN);
endmodule // adb_frame_timer
`default_nettype wire

// >>> dv/adb_data_buffer_chk.sv
/*
 Checker of the data buffer: stall, read, frame and trigger timing.
 Assumes binding to the buffer's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module adb_data_buffer_chk #(
   parameter int unsigned FRAME_CYCLES = 200
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire adb_pkg::adb_chmask_type chDirect,
   input wire adb_pkg::adb_chmask_type chControl,
   input wire logic linkSyncedTx,
   input wire logic linkSyncedRx,
   input wire logic physicalTimerSyncInput,
   input wire logic radioTimerSyncInput,
   input wire adb_pkg::adb_tcnt_type offEnc1,
   input wire adb_pkg::adb_tcnt_type offEnc2,
   input wire adb_pkg::adb_chips_type dioChips,
   input wire logic dioWrValid,
   input wire adb_pkg::adb_ch_type dmaWrCh,
   input wire logic dmaWrReady,
   input wire logic encRdReq,
   input wire adb_pkg::adb_ch_type encRdCh,
   input wire logic encRdValid,
   input wire adb_pkg::adb_chmask_type egFull,
   input wire adb_pkg::adb_chmask_type egEmpty,
   input wire logic fillStarted,
   input wire logic frameTick,
   input wire logic evtEnc1,
   input wire logic evtEnc2,
   input wire logic evtDio
);
   import adb_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   adb_tcnt_type sinceTick_ff;
   logic [10:0] sinceDio_ff;
   logic [10:0] dioPeriod;
   logic synced;
   logic directRd;
   assign synced = linkSyncedTx & linkSyncedRx;
   assign directRd = chDirect[encRdCh] & ~chControl[encRdCh];
   assign dioPeriod = (dioChips < 6'h04) ? 11'h080 : (dioChips > 6'h20) ? 11'h400 : {dioChips, 5'h00};
   // cycles since last tick and trigger
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sinceTick_ff <= '0;
         sinceDio_ff <= '0;
      end else if (ce) begin
         sinceTick_ff <= frameTick ? 21'h000001 : sinceTick_ff + {20'h00000, sinceTick_ff != '0};
         sinceDio_ff <= evtDio ? 11'h001 : sinceDio_ff + {10'h000, sinceDio_ff != '0};
      end
   end
   AST_FULL_STALL: assert property (egFull[dmaWrCh] |-> !dmaWrReady)
      else $error("ready when full");
   AST_DIO_PRIO: assert property (dioWrValid |-> !dmaWrReady)
      else $error("ready during direct write");
   AST_DIRECT_NO_DMA: assert property (chDirect[dmaWrCh] && !chControl[dmaWrCh] |-> !dmaWrReady)
      else $error("ready on direct channel");
   AST_STREAM_GATE: assert property (!chControl[dmaWrCh] && !fillStarted |-> !dmaWrReady)
      else $error("stream ready before fill");
   AST_CTRL_OPEN: assert property (chControl[dmaWrCh] && synced && !egFull[dmaWrCh] && !dioWrValid |-> dmaWrReady)
      else $error("control stalled");
   AST_FILL_START: assert property (ce && frameTick && synced |=> fillStarted)
      else $error("fill not started");
   AST_RD_ANSWER: assert property (ce && encRdReq && (!egEmpty[encRdCh] || directRd) |=> encRdValid)
      else $error("read not answered");
   AST_RD_EMPTY: assert property (ce && encRdReq && egEmpty[encRdCh] && !directRd |=> !encRdValid)
      else $error("empty read answered");
   AST_FRAME_PERIOD: assert property (ce && frameTick && sinceTick_ff != '0 && !$past(physicalTimerSyncInput) && !$past(physicalTimerSyncInput, 2) |-> sinceTick_ff == adb_tcnt_type'(FRAME_CYCLES))
      else $error("frame period");
   AST_ENC1_OFFSET: assert property (ce && evtEnc1 |-> sinceTick_ff == offEnc1)
      else $error("enc1 offset");
   AST_ENC2_OFFSET: assert property (ce && evtEnc2 |-> sinceTick_ff == offEnc2)
      else $error("enc2 offset");
   AST_DIO_PERIOD: assert property (ce && evtDio && sinceDio_ff != '0 && !$past(radioTimerSyncInput) && !$past(radioTimerSyncInput, 2) |-> sinceDio_ff == dioPeriod)
      else $error("trigger period");
   COV_FULL: cover property (egFull != '0 && !dmaWrReady);
   COV_TICK: cover property (frameTick && fillStarted);
   COV_DIO: cover property (evtDio);
endmodule // adb_data_buffer_chk
`default_nettype wire

// >>> dv/adb_dma_model.sv
/*
 Packet dma partner on the buffer's write port.
 Assumes its controls change just after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module adb_dma_model (
   input wire logic clk,
   input wire logic go,
   input wire logic abort,
   input wire logic slow,
   input wire adb_pkg::adb_ch_type ch,
   input wire logic [12:0] nWords,
   input wire logic dmaWrReady,
   output logic dmaWrValid,
   output adb_pkg::adb_ch_type dmaWrCh,
   output adb_pkg::adb_word_type dmaWrData,
   output logic [12:0] sent,
   output logic done
);
   import adb_pkg::*;
   assign dmaWrCh = ch;
   initial begin
      dmaWrValid = 1'b0;
      dmaWrData = 32'h00000000;
      sent = 13'h0000;
      done = 1'b1;
      forever begin
         @(posedge clk);
         if (go) begin
            done = 1'b0;
            sent = 13'h0000;
            while (sent < nWords && !abort) begin
               #1;
               dmaWrValid = 1'b1;
               dmaWrData = {6'h2A, ch, 24'(sent)};
               @(posedge clk);
               while (!dmaWrReady && !abort) @(posedge clk);
               if (dmaWrReady) sent = sent + 13'h0001;
               if (slow) begin
                  #1;
                  dmaWrValid = 1'b0;
                  @(posedge clk);
               end
            end
            done = 1'b1;
            #1;
            dmaWrValid = 1'b0;
            dmaWrData = ~dmaWrData;
         end
      end
   end
endmodule // adb_dma_model
`default_nettype wire

// >>> dv/adb_data_buffer_tb.sv
/*
 Bench of the data buffer: fifo queue model, dma partner, timing.
 Assumes the package and header on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
module adb_data_buffer_tb;
   import adb_pkg::*;
   localparam int FC = 200;
   logic clk, resetn, ce, directLen256, linkSyncedTx, linkSyncedRx, timerArm;
   logic physicalTimerSyncInput, radioTimerSyncInput, dmaWrValid, dmaWrReady, dioWrValid;
   logic encRdReq, encRdValid, decWrValid, ingRdReq, ingRdValid, ingDropClear, ingDropped;
   logic fillStarted, frameTick, evtEnc1, evtEnc2, evtTxDelta, evtRxPi, evtDio, timerRunning;
   logic pGo, pAbort, pSlow, pDone;
   logic [12:0] pN, pSent;
   logic [4:0] ev;
   adb_base_arr_type chBase;
   adb_depth_arr_type chDepth;
   adb_chmask_type chDirect, chControl, egFull, egEmpty, ingFull, ingEmpty;
   adb_tcnt_type offEnc1, offEnc2, offTxDelta, offRxPi;
   adb_chips_type dioChips;
   adb_ch_type dmaWrCh, dioWrCh, encRdCh, decWrCh, ingRdCh, pCh;
   adb_word_type dmaWrData, dioWrData, encRdData, decWrData, ingRdData;
   logic [31:0] egQ[4][$];
   int err_count, cmp_count, d, len, v, n, tm[5];
   adb_data_buffer #(.FRAME_CYCLES(FC)) uut (.*);
   adb_dma_model partner (.clk, .go(pGo), .abort(pAbort), .slow(pSlow), .ch(pCh), .nWords(pN),
      .dmaWrReady, .dmaWrValid, .dmaWrCh, .dmaWrData, .sent(pSent), .done(pDone));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic peek(input adb_ch_type ch, input logic exp);
      tick();
      pCh = ch;
      #1 check(dmaWrReady, exp);
   endtask
   // one read, answer a cycle later
   task automatic rd(input bit ing, input adb_ch_type ch, input logic [31:0] exp, input logic vld);
      tick();
      ingRdReq = ing;
      encRdReq = !ing;
      ingRdCh = ch;
      encRdCh = ch;
      tick();
      ingRdReq = 1'b0;
      encRdReq = 1'b0;
      check(ing ? ingRdValid : encRdValid, vld);
      if (vld) check(ing ? ingRdData : encRdData, exp);
   endtask
   // partner burst, aborted if stalled
   task automatic dma(input adb_ch_type ch, input int n, input bit slow, input int expN);
      tick();
      pCh = ch;
      pN = 13'(n);
      pSlow = slow;
      pGo = 1'b1;
      tick();
      pGo = 1'b0;
      for (int i = 0; i < n * 3 + 20 && pDone !== 1'b1; i++) tick();
      check(pSent, expN);
      if (pDone !== 1'b1) begin
         pAbort = 1'b1;
         repeat (4) tick();
         pAbort = 1'b0;
      end
      for (int k = 0; k < pSent; k++) egQ[ch].push_back({6'h2A, ch, 24'(k)});
   endtask
   initial begin
      void'($urandom(26345));
      {ce, resetn, directLen256, linkSyncedTx, linkSyncedRx, timerArm} = 6'h20;
      {physicalTimerSyncInput, radioTimerSyncInput, dioWrValid, encRdReq, decWrValid} = '0;
      {ingRdReq, ingDropClear, pGo, pAbort, pSlow, pCh, pN, dioWrCh, encRdCh} = '0;
      {decWrCh, ingRdCh, dioWrData, decWrData, dioChips} = '0;
      err_count = 0;
      cmp_count = 0;
      d = $urandom_range(2, 0);
      len = $urandom_range(1, 0) ? 64 : 32;
      directLen256 = (len == 64);
      // ch2 direct, ch3 control, contiguous when ch2 is 256 bytes
      chDepth = {3'h0, 3'h0, 3'(d), 3'h0};
      chBase = {7'(3 + (1 << d)), 7'(1 + (1 << d)), 7'h01, 7'h00};
      chDirect = 4'hC;
      chControl = 4'h8;
      offEnc1 = 21'h000064;
      offEnc2 = offEnc1 + 21'h00000A;
      offTxDelta = offEnc2 + 21'h00003C;
      offRxPi = offTxDelta + 21'h00000A;
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      physicalTimerSyncInput = 1'b1;
      tick();
      physicalTimerSyncInput = 1'b0;
      repeat (2) tick();
      check(timerRunning, 1'b0);
      timerArm = 1'b1;
      peek(2'h0, 1'b0);
      peek(2'h3, 1'b0);
      tick();
      {linkSyncedTx, linkSyncedRx} = 2'h3;
      peek(2'h3, 1'b1);
      peek(2'h0, 1'b0);
      dma(2'h3, 2, 1'b0, 2);
      $display("gating done");
      physicalTimerSyncInput = 1'b1;
      tick();
      physicalTimerSyncInput = 1'b0;
      for (int i = 0; i < 8 && frameTick !== 1'b1; i++) tick();
      check(frameTick, 1'b1);
      tm = '{default: 0};
      for (int i = 1; i <= FC; i++) begin
         tick();
         ev = {frameTick, evtRxPi, evtTxDelta, evtEnc2, evtEnc1};
         for (int k = 0; k < 5; k++) if (ev[k] === 1'b1) tm[k] = i;
      end
      check(tm[0], offEnc1);
      check(tm[1], offEnc2);
      check(tm[2], offTxDelta);
      check(tm[3], offRxPi);
      check(tm[4], FC);
      check(fillStarted, 1'b1);
      $display("frame done");
      dma(2'h0, 40, 1'b0, 32);
      check(egFull[0], 1'b1);
      dma(2'h1, (32 << d) + 4, 1'b1, 32 << d);
      tick();
      {decWrValid, decWrCh, decWrData} = {1'b1, 2'h0, 32'hC0DE0001};
      tick();
      decWrValid = 1'b0;
      rd(1'b1, 2'h0, 32'hC0DE0001, 1'b1);
      rd(1'b1, 2'h0, 32'h00000000, 1'b0);
      for (int c = 0; c < 4; c++) begin
         if (c == 2) continue;
         while (egQ[c].size() > 0) rd(1'b0, 2'(c), egQ[c].pop_front(), 1'b1);
         rd(1'b0, 2'(c), 32'h00000000, 1'b0);
      end
      check({ingDropped, ingFull[0], ingEmpty[0], egEmpty[0]}, 4'h3);
      $display("fifo done");
      for (int i = 0; i < len + 3; i++) begin
         tick();
         {dioWrValid, dioWrCh, dioWrData, pCh} = {1'b1, 2'h2, 32'h50000000 + i, 2'h3};
         #1 check(dmaWrReady, 1'b0);
      end
      tick();
      dioWrValid = 1'b0;
      for (int i = 0; i <= len; i++) begin
         n = i % len;
         rd(1'b0, 2'h2, 32'h50000000 + (n < 3 ? len + n : n), 1'b1);
      end
      $display("direct done");
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? $urandom_range(63, 0) : (k == 1 ? 2 : 40);
         tick();
         {timerArm, dioChips} = {1'b0, 6'(v)};
         tick();
         timerArm = 1'b1;
         tick();
         radioTimerSyncInput = 1'b1;
         tick();
         radioTimerSyncInput = 1'b0;
         for (int i = 0; i < 8 && evtDio !== 1'b1; i++) tick();
         n = 0;
         do begin
            tick();
            n++;
         end while (evtDio !== 1'b1 && n < 1100);
         check(n, (v < 4 ? 4 : (v > 32 ? 32 : v)) * 32);
      end
      $display("trigger done");
      conclude();
   end
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule // adb_data_buffer_tb
bind adb_data_buffer adb_data_buffer_chk #(.FRAME_CYCLES(FRAME_CYCLES)) chk (.*);
`default_nettype wire
